//--- hw/sac_pkg.sv
package sac_pkg;

	localparam logic [6:0] ADDR_RESET_CTRL  = 7'h00;
	localparam logic [6:0] ADDR_STREAM_CTRL = 7'h03;
	localparam logic [6:0] ADDR_POWER_CTRL  = 7'h08;
	localparam logic [6:0] ADDR_RESTART     = 7'h0b;
	localparam logic [6:0] ADDR_DRDY_CTRL   = 7'h11;
	localparam logic [6:0] ADDR_CHECKSUM_CT = 7'h13;
	localparam logic [6:0] ADDR_SCAL_CTRL   = 7'h17;
	localparam logic [6:0] ADDR_READY_STAT  = 7'h18;
	localparam logic [6:0] ADDR_CH_STATUS   = 7'h19;
	localparam logic [6:0] ADDR_RESULT_HI   = 7'h1a;
	localparam logic [6:0] ADDR_RESULT_MID  = 7'h1b;
	localparam logic [6:0] ADDR_RESULT_LO   = 7'h1c;
	localparam logic [6:0] ADDR_CHECKSUM    = 7'h1d;
	localparam logic [6:0] ADDR_CAL_OFFSET  = 7'h30;
	localparam logic [6:0] ADDR_CAL_GAIN    = 7'h33;

	localparam int         BIT_CHECKSUM_EN  = 4;
	localparam int         BIT_READY_AFTER  = 2;
	localparam int         BIT_CHECKSUM_HLD = 7;
	localparam int         BIT_STREAM_KIND  = 7;
	localparam int         BIT_CLEAR_CAL    = 7;
	localparam int         BIT_RESTART      = 0;

	localparam logic [7:0] RST_DRDY_CTRL    = 8'h03;
	localparam logic [7:0] RST_CHECKSUM_CT  = 8'h02;
	localparam logic [7:0] RST_STREAM_CTRL  = 8'h00;
	localparam logic [7:0] RST_SCAL_CTRL    = 8'h00;
	localparam logic [23:0] RST_CAL_OFFSET  = 24'h00_0000;
	localparam logic [23:0] RST_CAL_GAIN    = 24'h40_0000;

	localparam logic [7:0] RESET_KEY        = 8'hc3;
	localparam logic [7:0] INST_PAGE_WRITE  = 8'h10;
	localparam logic [1:0] SIZE_STREAM      = 2'h3;
	localparam logic [7:0] CRC_POLY         = 8'h31;

	localparam logic [1:0] PWR_CODE_ACTIVE  = 2'h0;
	localparam logic [1:0] PWR_CODE_DOWN    = 2'h1;
	localparam logic [1:0] PWR_CODE_STANDBY = 2'h3;

	localparam int         CLK_PERIOD_NS    = 40;
	localparam int         PWR_LATENCY_NS   = 15000;
	localparam int         PWR_LATENCY_CYC  = (PWR_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [23:0] RESULT_MAX      = 24'h7f_ffff;
	localparam logic [23:0] RESULT_MIN      = 24'h80_0000;

	typedef enum logic [3:0] {
		SAC_PH_INST  = 4'b0001,
		SAC_PH_PAGE  = 4'b0010,
		SAC_PH_WRITE = 4'b0100,
		SAC_PH_READ  = 4'b1000
	} sac_phase_type;

	typedef enum logic [2:0] {
		SAC_PW_ACTIVE  = 3'b001,
		SAC_PW_DOWN    = 3'b010,
		SAC_PW_STANDBY = 3'b100
	} sac_power_type;

endpackage

//--- hw/sac_crc8.sv
module sac_crc8 import sac_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       clear_i,
	input  wire logic       shift_i,
	input  wire logic       bit_i,
	output logic [7:0]      crc_o
);

	logic [7:0] crc;
	logic [7:0] next_crc;
	logic       feedback;

	// msb first, serial order
	always_comb begin
		feedback = crc[7] ^ bit_i;
		next_crc = crc;
		if (clear_i) begin
			next_crc = 8'h00;
		end else if (shift_i) begin
			next_crc = {crc[6:0], 1'b0} ^ (feedback ? CRC_POLY : 8'h00);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			crc <= 8'h00;
		end else begin
			crc <= next_crc;
		end
	end

	assign crc_o = crc;

endmodule // sac_crc8

//--- hw/sac_core.sv
module sac_core import sac_pkg::*; #(
	parameter int RAW_W = 26
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             sclk_i,
	input  wire logic             chip_select_n_i,
	input  wire logic             sdi_i,
	input  wire logic             conv_valid_i,
	input  wire logic [RAW_W-1:0] conv_raw_i,
	input  wire logic [7:0]       channel_status_i,
	output logic                  sdo_o,
	output logic                  sdo_oe_o,
	output logic                  drdy_n_o,
	output logic                  conv_run_o,
	output logic                  bias_on_o,
	output logic                  conv_restart_o
);

	////////////////////////////////////////////////////////////////////////////
	// state

	logic          sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, sdi_s1, sdi_s2;
	sac_phase_type phase, next_phase;
	sac_power_type pwr, next_pwr;
	logic [2:0]    bit_cnt, next_bit_cnt;
	logic [7:0]    rx, next_rx, tx, next_tx;
	logic [6:0]    addr, next_addr, base, next_base, raddr;
	logic [2:0]    page, next_page;
	logic [1:0]    size, next_size, left, next_left;
	logic [1:0]    pend_req, next_pend_req;
	logic [8:0]    pend_cnt, next_pend_cnt;
	logic [7:0]    drdy_ctrl, next_drdy_ctrl, crc_ctrl, next_crc_ctrl;
	logic [7:0]    strm_ctrl, next_strm_ctrl, scal_ctrl, next_scal_ctrl;
	logic [7:0]    ch_status, next_ch_status, rdata, in_byte;
	logic [23:0]   result, next_result, cal_off, next_cal_off;
	logic [23:0]   cal_gain, next_cal_gain;
	logic          key_armed, next_key_armed, data_fresh_n, next_data_fresh_n;
	logic          fresh_pend, next_fresh_pend;
	logic          next_sdo, next_sdo_oe, next_drdy_n, next_restart;
	logic          rise, fall, crc_clear, crc_shift, do_reset, periodic;
	logic [7:0]    crc_q;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [6:0] fn_step(input logic [6:0] a, input logic [6:0] b,
			input logic [2:0] range, input logic wrap);
		logic [6:0] last;
		last = b + {4'h0, range};
		if (wrap && (a == last)) begin
			fn_step = b;
		end else begin
			fn_step = a + 7'h01;
		end
	endfunction

	function automatic logic [23:0] fn_clamp(input logic [RAW_W-1:0] raw);
		logic over_pos, over_neg;
		over_pos = !raw[RAW_W-1] && (raw[RAW_W-2:23] != '0);
		over_neg = raw[RAW_W-1] && (raw[RAW_W-2:23] != '1);
		if (over_pos) begin
			fn_clamp = RESULT_MAX;
		end else if (over_neg) begin
			fn_clamp = RESULT_MIN;
		end else begin
			fn_clamp = raw[23:0];
		end
	endfunction

	function automatic logic [1:0] fn_pwr_code(input sac_power_type p);
		if (p == SAC_PW_DOWN) begin
			fn_pwr_code = PWR_CODE_DOWN;
		end else if (p == SAC_PW_STANDBY) begin
			fn_pwr_code = PWR_CODE_STANDBY;
		end else begin
			fn_pwr_code = PWR_CODE_ACTIVE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sclk_s1 <= 1'b1;
			sclk_s2 <= 1'b1;
			sclk_s3 <= 1'b1;
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			sdi_s1  <= 1'b0;
			sdi_s2  <= 1'b0;
		end else begin
			sclk_s1 <= sclk_i;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1   <= chip_select_n_i;
			cs_s2   <= cs_s1;
			sdi_s1  <= sdi_i;
			sdi_s2  <= sdi_s1;
		end
	end

	assign rise    = sclk_s2 && !sclk_s3;
	assign fall    = !sclk_s2 && sclk_s3;
	assign in_byte = {rx[6:0], sdi_s2};

	////////////////////////////////////////////////////////////////////////////
	// read address and read mux

	always_comb begin
		if (phase == SAC_PH_INST) begin
			raddr = {page, in_byte[3:0]};
		end else begin
			raddr = fn_step(addr, base, strm_ctrl[2:0],
				strm_ctrl[BIT_STREAM_KIND] && (size == SIZE_STREAM));
		end
	end

	always_comb begin
		if (raddr == ADDR_STREAM_CTRL) begin
			rdata = strm_ctrl;
		end else if (raddr == ADDR_POWER_CTRL) begin
			rdata = {6'h00, fn_pwr_code(pwr)};
		end else if (raddr == ADDR_DRDY_CTRL) begin
			rdata = drdy_ctrl;
		end else if (raddr == ADDR_CHECKSUM_CT) begin
			rdata = crc_ctrl;
		end else if (raddr == ADDR_SCAL_CTRL) begin
			rdata = scal_ctrl;
		end else if (raddr == ADDR_READY_STAT) begin
			rdata = {7'h00, data_fresh_n};
		end else if (raddr == ADDR_CH_STATUS) begin
			rdata = ch_status;
		end else if (raddr == ADDR_RESULT_HI) begin
			rdata = result[23:16];
		end else if (raddr == ADDR_RESULT_MID) begin
			rdata = result[15:8];
		end else if (raddr == ADDR_RESULT_LO) begin
			rdata = result[7:0];
		end else if (raddr == ADDR_CHECKSUM) begin
			rdata = ~crc_q;
		end else if (raddr >= ADDR_CAL_OFFSET && raddr < ADDR_CAL_GAIN) begin
			rdata = cal_off[8'(raddr - ADDR_CAL_OFFSET) * 8 +: 8];
		end else if (raddr >= ADDR_CAL_GAIN && raddr < ADDR_CAL_GAIN + 7'h03) begin
			rdata = cal_gain[8'(raddr - ADDR_CAL_GAIN) * 8 +: 8];
		end else begin
			rdata = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial protocol, registers, data-ready, power

	always_comb begin
		next_phase = phase;       next_bit_cnt = bit_cnt;   next_rx = rx;
		next_tx = tx;             next_addr = addr;         next_base = base;
		next_page = page;         next_size = size;         next_left = left;
		next_drdy_ctrl = drdy_ctrl;   next_crc_ctrl = crc_ctrl;
		next_strm_ctrl = strm_ctrl;   next_scal_ctrl = scal_ctrl;
		next_ch_status = ch_status;   next_result = result;
		next_cal_off = cal_off;       next_cal_gain = cal_gain;
		next_key_armed = key_armed;   next_data_fresh_n = data_fresh_n;
		next_fresh_pend = 1'b0;       next_drdy_n = drdy_n_o;
		next_sdo = sdo_o;             next_sdo_oe = sdo_oe_o;
		next_pwr = pwr;               next_pend_req = pend_req;
		next_pend_cnt = pend_cnt;     next_restart = 1'b0;
		crc_shift = 1'b0;             do_reset = 1'b0;
		periodic = conv_valid_i && (pwr == SAC_PW_ACTIVE);

		// power request settles after the fixed latency
		if (pend_cnt != 9'd0) begin
			next_pend_cnt = pend_cnt - 9'd1;
			if (pend_cnt == 9'd1) begin
				if (pend_req == PWR_CODE_DOWN) begin
					next_pwr = SAC_PW_DOWN;
				end else if (pend_req == PWR_CODE_STANDBY) begin
					next_pwr = SAC_PW_STANDBY;
				end else begin
					next_pwr = SAC_PW_ACTIVE;
				end
			end
		end

		if (cs_s2) begin
			next_phase = SAC_PH_INST;
			next_bit_cnt = 3'd0;
			next_sdo_oe = 1'b0;
		end else if (rise) begin
			next_rx = in_byte;
			next_bit_cnt = bit_cnt + 3'd1;
			if (bit_cnt == 3'd7) begin
				case (phase)
					SAC_PH_INST: begin
						if (in_byte == INST_PAGE_WRITE) begin
							next_phase = SAC_PH_PAGE;
						end else begin
							next_addr = {page, in_byte[3:0]};
							next_base = {page, in_byte[3:0]};
							next_size = in_byte[6:5];
							next_left = in_byte[6:5];
							next_tx = rdata;
							next_phase = in_byte[7] ? SAC_PH_READ : SAC_PH_WRITE;
						end
					end
					SAC_PH_PAGE: begin
						next_page = in_byte[2:0];
						next_phase = SAC_PH_INST;
					end
					SAC_PH_WRITE: begin
						if (addr == ADDR_RESET_CTRL && in_byte == RESET_KEY) begin
							if (scal_ctrl[1:0] != 2'h0 && !key_armed) begin
								next_key_armed = 1'b1;
							end else begin
								do_reset = 1'b1;
							end
						end else if (addr == ADDR_STREAM_CTRL) begin
							next_strm_ctrl = in_byte;
						end else if (addr == ADDR_POWER_CTRL) begin
							// refused while a request is settling
							if (pend_cnt == 9'd0 && in_byte[1:0] != 2'h2 &&
									!(pwr == SAC_PW_DOWN && in_byte[1:0] == PWR_CODE_STANDBY)) begin
								next_pend_req = in_byte[1:0];
								next_pend_cnt = 9'(PWR_LATENCY_CYC);
							end
						end else if (addr == ADDR_RESTART) begin
							next_restart = in_byte[BIT_RESTART];
						end else if (addr == ADDR_DRDY_CTRL) begin
							next_drdy_ctrl = in_byte;
						end else if (addr == ADDR_CHECKSUM_CT) begin
							next_crc_ctrl = in_byte;
						end else if (addr == ADDR_SCAL_CTRL) begin
							next_scal_ctrl = in_byte;
						end else if (addr >= ADDR_CAL_OFFSET && addr < ADDR_CAL_GAIN) begin
							next_cal_off[8'(addr - ADDR_CAL_OFFSET) * 8 +: 8] = in_byte;
						end else if (addr >= ADDR_CAL_GAIN && addr < ADDR_CAL_GAIN + 7'h03) begin
							next_cal_gain[8'(addr - ADDR_CAL_GAIN) * 8 +: 8] = in_byte;
						end
					end
					default: begin
						if (addr == ADDR_RESULT_HI) begin
							next_data_fresh_n = 1'b1;
						end
						if ((addr == ADDR_RESULT_LO && !crc_ctrl[BIT_READY_AFTER]) ||
								(addr == ADDR_CHECKSUM && crc_ctrl[BIT_READY_AFTER])) begin
							next_drdy_n = 1'b1;
						end
						next_tx = rdata;
					end
				endcase
				if (phase == SAC_PH_WRITE || phase == SAC_PH_READ) begin
					next_addr = raddr;
					if (size != SIZE_STREAM) begin
						if (left == 2'd0) begin
							next_phase = SAC_PH_PAGE;
						end else begin
							next_left = left - 2'd1;
						end
					end
				end
			end
		end else if (fall) begin
			next_sdo_oe = (phase == SAC_PH_READ);
			if (phase == SAC_PH_READ) begin
				next_sdo = tx[7];
				next_tx = {tx[6:0], 1'b0};
				crc_shift = crc_ctrl[BIT_CHECKSUM_EN] && (addr != ADDR_CHECKSUM);
			end
		end

		// a new result: periodic deassertion, then data-ready low
		if (periodic) begin
			next_drdy_n = 1'b1;
			next_result = fn_clamp(conv_raw_i);
			next_ch_status = channel_status_i;
			next_data_fresh_n = 1'b0;
			next_fresh_pend = 1'b1;
		end else if (fresh_pend) begin
			next_drdy_n = 1'b0;
		end

		if (do_reset) begin
			next_key_armed = 1'b0;
			next_drdy_ctrl = RST_DRDY_CTRL;
			next_crc_ctrl = RST_CHECKSUM_CT;
			next_strm_ctrl = RST_STREAM_CTRL;
			next_scal_ctrl = RST_SCAL_CTRL;
			next_result = 24'h00_0000;
			next_ch_status = 8'h00;
			next_drdy_n = 1'b1;
			next_restart = 1'b1;
			next_pend_cnt = 9'd0;
			if (scal_ctrl[BIT_CLEAR_CAL]) begin
				next_cal_off = RST_CAL_OFFSET;
				next_cal_gain = RST_CAL_GAIN;
			end
			if (pwr == SAC_PW_DOWN) begin
				next_pwr = SAC_PW_ACTIVE;
			end
		end

		crc_clear = cs_s2 || (periodic && !drdy_n_o && !drdy_ctrl[BIT_CHECKSUM_HLD]) ||
			(next_drdy_n && !drdy_n_o && !periodic);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			phase <= SAC_PH_INST;   bit_cnt <= 3'd0;    rx <= 8'h00;
			tx <= 8'h00;            addr <= 7'h00;      base <= 7'h00;
			page <= 3'd0;           size <= 2'd0;       left <= 2'd0;
			drdy_ctrl <= RST_DRDY_CTRL;     crc_ctrl <= RST_CHECKSUM_CT;
			strm_ctrl <= RST_STREAM_CTRL;   scal_ctrl <= RST_SCAL_CTRL;
			ch_status <= 8'h00;             result <= 24'h00_0000;
			cal_off <= RST_CAL_OFFSET;      cal_gain <= RST_CAL_GAIN;
			key_armed <= 1'b0;              data_fresh_n <= 1'b1;
			fresh_pend <= 1'b0;             drdy_n_o <= 1'b1;
			sdo_o <= 1'b0;                  sdo_oe_o <= 1'b0;
			pwr <= SAC_PW_ACTIVE;           pend_req <= PWR_CODE_ACTIVE;
			pend_cnt <= 9'd0;               conv_restart_o <= 1'b0;
			conv_run_o <= 1'b0;             bias_on_o <= 1'b0;
		end else begin
			phase <= next_phase;    bit_cnt <= next_bit_cnt;    rx <= next_rx;
			tx <= next_tx;          addr <= next_addr;          base <= next_base;
			page <= next_page;      size <= next_size;          left <= next_left;
			drdy_ctrl <= next_drdy_ctrl;    crc_ctrl <= next_crc_ctrl;
			strm_ctrl <= next_strm_ctrl;    scal_ctrl <= next_scal_ctrl;
			ch_status <= next_ch_status;    result <= next_result;
			cal_off <= next_cal_off;        cal_gain <= next_cal_gain;
			key_armed <= next_key_armed;    data_fresh_n <= next_data_fresh_n;
			fresh_pend <= next_fresh_pend;  drdy_n_o <= next_drdy_n;
			sdo_o <= next_sdo;              sdo_oe_o <= next_sdo_oe;
			pwr <= next_pwr;                pend_req <= next_pend_req;
			pend_cnt <= next_pend_cnt;      conv_restart_o <= next_restart;
			conv_run_o <= (next_pwr == SAC_PW_ACTIVE);
			bias_on_o <= (next_pwr != SAC_PW_DOWN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checksum engine

	sac_crc8 u_crc (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.clear_i (crc_clear),
		.shift_i (crc_shift),
		.bit_i   (tx[7]),
		.crc_o   (crc_q)
	);

endmodule // sac_core

//--- tb/sac_chk.sv
module sac_chk import sac_pkg::*; #(
	parameter int RAW_W = 26
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             sclk_i,
	input  wire logic             chip_select_n_i,
	input  wire logic             sdi_i,
	input  wire logic             conv_valid_i,
	input  wire logic [RAW_W-1:0] conv_raw_i,
	input  wire logic [7:0]       channel_status_i,
	input  wire logic             sdo_o,
	input  wire logic             sdo_oe_o,
	input  wire logic             drdy_n_o,
	input  wire logic             conv_run_o,
	input  wire logic             bias_on_o,
	input  wire logic             conv_restart_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_restart_pulse: assert property (conv_restart_o |=> !conv_restart_o)
		else $error("restart pulse longer than one cycle");
	a_run_needs_bias: assert property (conv_run_o |-> bias_on_o)
		else $error("converter running without bias");
	a_periodic_deassert: assert property (conv_valid_i && conv_run_o |=> drdy_n_o)
		else $error("data ready not deasserted at new result");
	a_ready_cause: assert property ($fell(drdy_n_o) |-> $past(conv_valid_i, 2))
		else $error("data ready asserted without new result");
	a_power_settle: assert property ($changed(bias_on_o) |=> $stable(bias_on_o)[*8])
		else $error("power state changed again too soon");
	a_oe_release: assert property ($rose(chip_select_n_i) ##1 chip_select_n_i[*5] |-> !sdo_oe_o)
		else $error("serial output still driven after frame end");
	a_oe_start: assert property ($rose(sdo_oe_o) |-> !$past(chip_select_n_i, 3))
		else $error("serial output driven outside a frame");
	a_leave_down: assert property (conv_restart_o && $rose(bias_on_o) |-> conv_run_o)
		else $error("register reset left power-down but not running");

	c_ready: cover property ($fell(drdy_n_o));
	c_restart: cover property (conv_restart_o);
	c_down: cover property ($fell(bias_on_o));
	c_standby: cover property (bias_on_o && !conv_run_o);
endmodule // sac_chk

bind sac_core sac_chk #(.RAW_W(RAW_W)) u_sac_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
	.sdi_i(sdi_i), .conv_valid_i(conv_valid_i), .conv_raw_i(conv_raw_i),
	.channel_status_i(channel_status_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
	.drdy_n_o(drdy_n_o), .conv_run_o(conv_run_o), .bias_on_o(bias_on_o),
	.conv_restart_o(conv_restart_o)
);

//--- tb/sac_host.sv
module sac_host (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      chip_select_n_o,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk_o          = 1'b1;
		chip_select_n_o = 1'b1;
		sdi_o           = 1'b0;
	end

	// frame edge; idle data line shows the inverse of its last bit
	task automatic frame(input logic on);
		repeat (4) @(posedge clk_i);
		chip_select_n_o <= !on;
		if (!on) begin
			sdi_o <= !sdi_o;
		end
		repeat (8) @(posedge clk_i);
	endtask

	// one byte, msb first, 320 ns serial period, data read just before the next fall
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o <= 1'b0;
			sdi_o  <= tx[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			rx[i] = sdo_i;
		end
	endtask
endmodule // sac_host

//--- tb/sensor_adc_crc_power_reset_tb_top.sv
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module sensor_adc_crc_power_reset_tb_top;
	import sac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i, rstn_i, conv_valid_i, sclk, cs_n, sdi, sdo, drdy_n, run, bias, rst_p;
	logic [25:0] conv_raw_i;
	logic [7:0]  channel_status_i;
	logic [7:0]  rx [5];
	logic [7:0]  wb [3];
	int          error_cnt, compares, restarts, n;
	logic [25:0] raws [3] = '{26'h1ff_ffff, 26'h200_0000, 26'h000_1234};
	logic [23:0] outs [3] = '{24'h7f_ffff, 24'h80_0000, 24'h00_1234};
	logic [6:0]  ra [6] = '{ADDR_CHECKSUM_CT, ADDR_DRDY_CTRL, ADDR_STREAM_CTRL,
		ADDR_POWER_CTRL, 7'h7f, ADDR_SCAL_CTRL};
	logic [7:0]  re [6] = '{RST_CHECKSUM_CT, RST_DRDY_CTRL, RST_STREAM_CTRL,
		{6'h00, PWR_CODE_ACTIVE}, 8'h00, RST_SCAL_CTRL};

	sac_core #(.RAW_W(26)) u_sac_core (
		.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .chip_select_n_i(cs_n), .sdi_i(sdi),
		.conv_valid_i(conv_valid_i), .conv_raw_i(conv_raw_i),
		.channel_status_i(channel_status_i), .sdo_o(sdo), .sdo_oe_o(), .drdy_n_o(drdy_n),
		.conv_run_o(run), .bias_on_o(bias), .conv_restart_o(rst_p)
	);
	sac_host u_sac_host (
		.clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .chip_select_n_o(cs_n), .sdi_o(sdi)
	);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (rst_p === 1'b1) begin
			restarts++;
		end
	end

	task automatic wrap_up();
		$display("error_cnt=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [7:0] crc_of(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction

	task automatic xact(input logic [6:0] a, input logic r, input logic [1:0] sz,
		input int cnt, input logic pg);
		logic [7:0] d;
		u_sac_host.frame(1'b1);
		if (pg) begin
			u_sac_host.xfer(INST_PAGE_WRITE, d);
			u_sac_host.xfer({5'h00, a[6:4]}, d);
		end
		u_sac_host.xfer({r, sz, 1'b0, a[3:0]}, d);
		for (int i = 0; i < cnt; i++) begin
			u_sac_host.xfer(wb[i % 3], rx[i]);
		end
		u_sac_host.frame(1'b0);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		wb[0] = v;
		xact(a, 1'b0, 2'h0, 1, 1'b1);
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		xact(a, 1'b1, 2'h0, 1, 1'b1);
		`CHK(rx[0], e)
	endtask

	// one converter result pulse
	task automatic conv(input logic [25:0] r, input logic [7:0] s);
		conv_raw_i       <= r;
		channel_status_i <= s;
		conv_valid_i     <= 1'b1;
		@(posedge clk_i);
		conv_valid_i <= 1'b0;
	endtask

	// wait out the power latency, then check code and pins
	task automatic settle(input logic [1:0] e);
		repeat (400) @(posedge clk_i);
		rd_chk(ADDR_POWER_CTRL, {6'h00, e});
		`CHK({run, bias}, {e == PWR_CODE_ACTIVE, e != PWR_CODE_DOWN})
	endtask

	initial begin
		conv_valid_i     = 1'b0;
		conv_raw_i       = '0;
		channel_status_i = 8'h00;
		rstn_i           = 1'b0;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		foreach (ra[i]) rd_chk(ra[i], re[i]);
		wr(ADDR_CHECKSUM_CT, 8'h16);
		rd_chk(ADDR_CHECKSUM_CT, 8'h16);
		////////////////////////////////////////////////////////////////////////////
		for (int k = 0; k < 3; k++) begin
			conv_raw_i       <= raws[k];
			channel_status_i <= 8'ha5 + 8'(k);
			conv_valid_i     <= 1'b1;
			@(posedge clk_i);
			conv_valid_i <= 1'b0;
			for (int i = 0; i < 40 && drdy_n !== 1'b0; i++) begin
				@(posedge clk_i);
			end
			if (drdy_n !== 1'b0) begin
				error_cnt++;
				wrap_up();
			end
			xact(ADDR_CH_STATUS, 1'b1, SIZE_STREAM, 5, 1'b1);
			`CHK(rx[0], 8'ha5 + 8'(k))
			`CHK({rx[1], rx[2], rx[3]}, outs[k])
			`CHK(rx[4], ~crc_of({8'ha5 + 8'(k), outs[k]}))
			`CHK(drdy_n, 1'b1)
		end
		// new result lands mid status byte; hold keeps the running checksum
		wr(ADDR_DRDY_CTRL, 8'h83);
		conv(26'h000_0055, 8'h3c);
		repeat (4) @(posedge clk_i);
		`CHK(drdy_n, 1'b0)
		fork
			xact(ADDR_CH_STATUS, 1'b1, SIZE_STREAM, 5, 1'b1);
			begin
				repeat (226) @(posedge clk_i);
				conv(26'h3ff_ff00, 8'hc3);
			end
		join
		`CHK(rx[0], 8'h3c)
		`CHK({rx[1], rx[2], rx[3]}, 24'hff_ff00)
		`CHK(rx[4], ~crc_of({8'h3c, 24'hff_ff00}))
		// wrapping stream on the checksum register alone
		wr(ADDR_STREAM_CTRL, 8'h80);
		xact(ADDR_CHECKSUM, 1'b1, SIZE_STREAM, 3, 1'b1);
		`CHK({rx[0], rx[1], rx[2]}, 24'hff_ffff)
		////////////////////////////////////////////////////////////////////////////
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_DOWN});
		rd_chk(ADDR_POWER_CTRL, {6'h00, PWR_CODE_ACTIVE});
		settle(PWR_CODE_DOWN);
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_STANDBY});
		settle(PWR_CODE_DOWN);
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_ACTIVE});
		settle(PWR_CODE_ACTIVE);
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_STANDBY});
		settle(PWR_CODE_STANDBY);
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_ACTIVE});
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_DOWN});
		settle(PWR_CODE_ACTIVE);
		////////////////////////////////////////////////////////////////////////////
		wb = '{8'h11, 8'h22, 8'h33};
		xact(ADDR_CAL_OFFSET, 1'b0, 2'h2, 3, 1'b1);
		xact(ADDR_CAL_OFFSET, 1'b1, 2'h2, 3, 1'b0);
		`CHK({rx[0], rx[1], rx[2]}, 24'h11_2233)
		wr(ADDR_POWER_CTRL, {6'h00, PWR_CODE_DOWN});
		settle(PWR_CODE_DOWN);
		n = restarts;
		wr(ADDR_RESET_CTRL, RESET_KEY);
		`CHK(restarts, n + 1)
		`CHK(bias, 1'b1)
		rd_chk(ADDR_CHECKSUM_CT, RST_CHECKSUM_CT);
		rd_chk(ADDR_STREAM_CTRL, RST_STREAM_CTRL);
		xact(ADDR_CAL_OFFSET, 1'b1, 2'h2, 3, 1'b1);
		`CHK({rx[0], rx[1], rx[2]}, 24'h11_2233)
		wr(ADDR_SCAL_CTRL, 8'h80);
		wr(ADDR_RESET_CTRL, RESET_KEY);
		xact(ADDR_CAL_OFFSET, 1'b1, 2'h2, 3, 1'b1);
		`CHK({rx[2], rx[1], rx[0]}, RST_CAL_OFFSET)
		wr(ADDR_SCAL_CTRL, 8'h01);
		wr(ADDR_RESET_CTRL, RESET_KEY);
		rd_chk(ADDR_SCAL_CTRL, 8'h01);
		wr(ADDR_RESET_CTRL, RESET_KEY);
		rd_chk(ADDR_SCAL_CTRL, RST_SCAL_CTRL);
		// ready_after_checksum cleared: data-ready ends at the low result byte
		conv(26'h000_0077, 8'h00);
		repeat (4) @(posedge clk_i);
		`CHK(drdy_n, 1'b0)
		xact(ADDR_RESULT_HI, 1'b1, 2'h2, 3, 1'b1);
		`CHK({drdy_n, rx[2]}, 9'h177)
		n = restarts;
		wr(ADDR_RESTART, 8'h01);
		`CHK(restarts, n + 1)
		wrap_up();
	end
endmodule // sensor_adc_crc_power_reset_tb_top
